// ---- hdl/eer_dev.sv ----
// eeprom two-wire target: array, secure page, config, id and lock reads
// Summary of operation
// - acked array, secure page or id read byte: keep sending next locations
// - array reads wrap to zero at memory end
// - secure read: dummy write, then special read
// - secure page counter wraps within page
// - config read drives unused bits as one
// - acked config read repeats same byte
// - id dummy write selects region 01
// - id returned as sixteen successive bytes
// - id wraps to first byte when acked
// - secure write acked unlocked, refused locked
// - controller ends probe with start, stop
// - lock read: region 10 dummy write, read
// - lock byte bit 1 shows page locked
// - array reads ff, config delivered as 1d
// - special access needs matching select bits
// - address byte: header, select, direction
// - nack then stop ends session
// - config: select bits 7:5, protect bit 1
`timescale 1ns/1ps
module eer_dev #(
  parameter int           DEPTH   = eer_pkg::MEM_DEPTH,
  parameter int           AW      = $clog2(eer_pkg::MEM_DEPTH),
  parameter logic [127:0] UID_VAL = 128'h0123456789abcdef0f1e2d3c4b5a6978
  // uid value is arbitrary, a stand-in for the factory id
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // shared with neighbouring write logic
  input  wire logic [7:0]    cfg_byte,
  input  wire logic          page_locked,
  output logic      [AW-1:0] addr_count,
  output logic               in_session,
  // link
  eer_if.dev                 bus
);

  // ----------------------------------------------------------------------
  // read data and counter helpers
  // ----------------------------------------------------------------------
  // byte returned for the current mode and counter
  function automatic logic [7:0] rd_byte(input logic          spec,
                                         input logic [1:0]    region,
                                         input logic [AW-1:0] a,
                                         input logic [7:0]    cfg,
                                         input logic          lock);
    logic [3:0] k;
    k = a[3:0];
    rd_byte = eer_pkg::ARRAY_FILL;
    if (spec) begin
      unique case (region)
        eer_pkg::REGION_SPAGE: rd_byte = eer_pkg::ARRAY_FILL;
        eer_pkg::REGION_UID:   rd_byte = UID_VAL[8*(15-k) +: 8];
        eer_pkg::REGION_LOCK: begin
          rd_byte = 8'h00;
          rd_byte[eer_pkg::LOCK_BIT] = lock;
        end
        eer_pkg::REGION_CFG:   rd_byte = cfg | eer_pkg::CFG_UNUSED;
      endcase
    end
  endfunction

  // counter step after an acknowledged byte
  function automatic logic [AW-1:0] next_addr(input logic          spec,
                                              input logic [1:0]    region,
                                              input logic [AW-1:0] a);
    next_addr = a;
    if (!spec) begin
      next_addr = (a == AW'(DEPTH - 1)) ? '0 : a + 1'b1;
    end else begin
      unique case (region)
        eer_pkg::REGION_SPAGE: next_addr[5:0] = a[5:0] + 6'h1;
        eer_pkg::REGION_UID:   next_addr[3:0] = a[3:0] + 4'h1;
        eer_pkg::REGION_LOCK:  next_addr = a;
        eer_pkg::REGION_CFG:   next_addr = a;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic scl_rise, scl_fall, start_ev, stop_ev;

  // third stage only feeds edge detection, never the first stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m_q <= 1'b1; scl_s_q <= 1'b1; scl_p_q <= 1'b1;
      sda_m_q <= 1'b1; sda_s_q <= 1'b1; sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= bus.scl; scl_s_q <= scl_m_q; scl_p_q <= scl_s_q;
      sda_m_q <= bus.sda; sda_s_q <= sda_m_q; sda_p_q <= sda_s_q;
    end
  end

  assign scl_rise = scl_s_q && !scl_p_q;
  assign scl_fall = !scl_s_q && scl_p_q;
  assign start_ev = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign stop_ev  = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

  // ----------------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------------
  eer_pkg::eer_dev_state_e st_q, st_d;
  logic [3:0]    cnt_q, cnt_d;
  logic [7:0]    sr_q, sr_d;
  logic [1:0]    idx_q, idx_d;       // 0 address byte, 1 hi, 2 lo, 3 data
  logic          rw_q, rw_d;
  logic          spec_q, spec_d;
  logic [1:0]    region_q, region_d;
  logic [7:0]    hi_q, hi_d;
  logic [AW-1:0] addr_q, addr_d;
  logic          ackd_q, ackd_d;
  logic          sda_low_q, sda_low_d;
  logic [7:0]    cur_byte;
  logic [15:0]   full_addr;
  logic          sel_ok;
  logic          in_sess_q;

  assign cur_byte  = rd_byte(spec_q, region_q, addr_q, cfg_byte, page_locked);
  assign full_addr = {hi_q, sr_q};
  assign sel_ok    = sr_q[3:1] == cfg_byte[eer_pkg::SEL_MSB:eer_pkg::SEL_LSB];
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_low_q;
  assign addr_count     = addr_q;
  assign in_session     = in_sess_q;

  // bits are taken on scl rise, data and ack are changed after scl fall
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; sr_d = sr_q; idx_d = idx_q;
    rw_d = rw_q; spec_d = spec_q; region_d = region_q; hi_d = hi_q;
    addr_d = addr_q; ackd_d = ackd_q; sda_low_d = sda_low_q;
    if (stop_ev) begin
      st_d = eer_pkg::S_IDLE;
      sda_low_d = 1'b0;
    end else if (start_ev) begin
      st_d = eer_pkg::S_RX;
      cnt_d = 4'h0;
      idx_d = 2'h0;
      sda_low_d = 1'b0;
    end else begin
      unique case (st_q)
        eer_pkg::S_IDLE: ;
        eer_pkg::S_RX: begin
          if (scl_rise) begin
            sr_d = {sr_q[6:0], sda_s_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            sda_low_d = 1'b1;
            st_d = eer_pkg::S_RACK;
            unique case (idx_q)
              2'h0: begin
                if (sel_ok && (sr_q[7:4] == eer_pkg::HDR_ARRAY ||
                               sr_q[7:4] == eer_pkg::HDR_SPECIAL)) begin
                  spec_d = sr_q[7:4] == eer_pkg::HDR_SPECIAL;
                  rw_d = sr_q[0];
                end else begin
                  sda_low_d = 1'b0;
                  st_d = eer_pkg::S_IDLE;
                end
              end
              2'h1: begin
                hi_d = sr_q;
                if (spec_q) begin
                  region_d = sr_q[eer_pkg::REG_MSB:eer_pkg::REG_LSB];
                end
              end
              2'h2: addr_d = spec_q ? AW'(sr_q) : full_addr[AW-1:0];
              2'h3: begin
                if (spec_q && region_q == eer_pkg::REGION_SPAGE &&
                    page_locked) begin
                  sda_low_d = 1'b0;
                  st_d = eer_pkg::S_IDLE;
                end
              end
            endcase
          end
        end
        eer_pkg::S_RACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (idx_q == 2'h0 && rw_q) begin
              st_d = eer_pkg::S_TX;
              sr_d = cur_byte;
              sda_low_d = !cur_byte[7];
            end else begin
              st_d = eer_pkg::S_RX;
              sda_low_d = 1'b0;
              if (idx_q != 2'h3) begin
                idx_d = idx_q + 2'h1;
              end
            end
          end
        end
        eer_pkg::S_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              st_d = eer_pkg::S_TACK;
              sda_low_d = 1'b0;
            end else begin
              sr_d = {sr_q[6:0], 1'b0};
              sda_low_d = !sr_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        eer_pkg::S_TACK: begin
          if (scl_rise) begin
            ackd_d = !sda_s_q;
            if (!sda_s_q) begin
              addr_d = next_addr(spec_q, region_q, addr_q);
            end
          end else if (scl_fall) begin
            if (ackd_q) begin
              st_d = eer_pkg::S_TX;
              sr_d = cur_byte;
              sda_low_d = !cur_byte[7];
              cnt_d = 4'h0;
            end else begin
              st_d = eer_pkg::S_IDLE;
            end
          end
        end
        default: st_d = eer_pkg::S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= eer_pkg::S_IDLE;
      cnt_q <= 4'h0; sr_q <= 8'h00; idx_q <= 2'h0;
      rw_q <= 1'b0; spec_q <= 1'b0; region_q <= 2'h0; hi_q <= 8'h00;
      addr_q <= '0; ackd_q <= 1'b0; sda_low_q <= 1'b0;
      in_sess_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d; sr_q <= sr_d; idx_q <= idx_d;
      rw_q <= rw_d; spec_q <= spec_d; region_q <= region_d; hi_q <= hi_d;
      addr_q <= addr_d; ackd_q <= ackd_d; sda_low_q <= sda_low_d;
      in_sess_q <= st_d != eer_pkg::S_IDLE;
    end
  end

endmodule

// ---- hdl/eer_pkg.sv ----
// shared constants and types for the eeprom read-path target and controller
package eer_pkg;

  // ----------------------------------------------------------------------
  // target address byte
  // ----------------------------------------------------------------------
  localparam logic [3:0] HDR_ARRAY    = 4'ha;
  localparam logic [3:0] HDR_SPECIAL  = 4'hb;
  localparam int         SEL_MSB      = 7;   // select bits in config byte
  localparam int         SEL_LSB      = 5;
  localparam int         WP_BIT       = 1;   // soft_write_protect_flag

  // ----------------------------------------------------------------------
  // special regions, chosen by bits 2:1 of the high address byte
  // ----------------------------------------------------------------------
  localparam int         REG_MSB      = 2;
  localparam int         REG_LSB      = 1;
  localparam logic [1:0] REGION_SPAGE = 2'b00;
  localparam logic [1:0] REGION_UID   = 2'b01;
  localparam logic [1:0] REGION_LOCK  = 2'b10;
  localparam logic [1:0] REGION_CFG   = 2'b11;
  localparam int         LOCK_BIT     = 1;

  // ----------------------------------------------------------------------
  // memory shape and delivery values
  // ----------------------------------------------------------------------
  localparam int         MEM_DEPTH    = 8192;
  localparam int         SPAGE_DEPTH  = 64;
  localparam int         UID_BYTES    = 16;
  localparam logic [7:0] ARRAY_FILL   = 8'hff;
  localparam logic [7:0] CFG_RESET    = 8'h1d;
  localparam logic [7:0] CFG_UNUSED   = 8'h1d;

  // ----------------------------------------------------------------------
  // controller registers and link timing
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_CMD     = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam logic [1:0]  OP_START    = 2'h0;
  localparam logic [1:0]  OP_STOP     = 2'h1;
  localparam logic [1:0]  OP_WRITE    = 2'h2;
  localparam logic [1:0]  OP_READ     = 2'h3;
  localparam int          CMD_ACK_BIT = 2;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          LINK_PERIOD_NS = 800;
  localparam int          QTR_CYCLES  = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RX   = 5'h02,
    S_RACK = 5'h04,
    S_TX   = 5'h08,
    S_TACK = 5'h10
  } eer_dev_state_e;

  typedef enum logic [3:0] {
    C_IDLE  = 4'h1,
    C_START = 4'h2,
    C_BIT   = 4'h4,
    C_STOP  = 4'h8
  } eer_ctl_state_e;

endpackage

// ---- hdl/eer_if.sv ----
// two-wire link between the eeprom target and its bus controller
`timescale 1ns/1ps
interface eer_if;
  // open-drain drives: enable high pulls the line to the output value
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // wired-and with pull-up
  assign scl = !(ctl_scl_oe && !ctl_scl_o);
  assign sda = !((ctl_sda_oe && !ctl_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport ctl (input scl, input sda, output ctl_scl_o, output ctl_scl_oe,
               output ctl_sda_o, output ctl_sda_oe);
endinterface

// ---- hdl/eer_ctl.sv ----
// bus controller end: apb command registers driving the two-wire link
`timescale 1ns/1ps
module eer_ctl #(
  parameter int QTR = eer_pkg::QTR_CYCLES
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  eer_if.ctl               bus
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  eer_pkg::eer_ctl_state_e st_q, st_d;
  logic [7:0]  tick_q, tick_d;
  logic [1:0]  ph_q, ph_d;
  logic [3:0]  bitn_q, bitn_d;
  logic [8:0]  sh_q, sh_d;
  logic [8:0]  rx_q, rx_d;
  logic        ack_q, ack_d;
  logic        scl_low_q, scl_low_d;
  logic        sda_low_q, sda_low_d;
  logic        sda_m_q, sda_s_q;
  logic [31:0] prdata_d;
  logic        pready_d;
  logic        tick;
  logic        wr_cmd;

  assign bus.ctl_scl_o  = 1'b0;
  assign bus.ctl_sda_o  = 1'b0;
  assign bus.ctl_scl_oe = scl_low_q;
  assign bus.ctl_sda_oe = sda_low_q;
  logic [31:0] prdata_q_w;
  logic        pready_q_w;
  assign prdata  = prdata_q_w;
  assign pslverr = 1'b0;
  assign pready  = pready_q_w;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // commands arriving while busy are dropped; software polls busy first
  always_comb begin
    st_d = st_q; tick_d = tick_q; ph_d = ph_q; bitn_d = bitn_q;
    sh_d = sh_q; rx_d = rx_q; ack_d = ack_q;
    scl_low_d = scl_low_q; sda_low_d = sda_low_q;
    pready_d = psel && !penable;
    prdata_d = 32'h0;
    if (psel && !penable && !pwrite && paddr == eer_pkg::OFS_STATUS) begin
      prdata_d = {16'h0, rx_q[8:1], 6'h0, ack_q, st_q != eer_pkg::C_IDLE};
    end
    wr_cmd = psel && penable && pready_q_w && pwrite &&
             paddr == eer_pkg::OFS_CMD && st_q == eer_pkg::C_IDLE;
    tick = tick_q == 8'(QTR - 1);
    tick_d = tick ? 8'h0 : tick_q + 8'h1;
    unique case (st_q)
      eer_pkg::C_IDLE: begin
        tick_d = 8'h0;
        ph_d = 2'h0;
        bitn_d = 4'h0;
        if (wr_cmd) begin
          scl_low_d = 1'b1;
          unique case (pwdata[1:0])
            eer_pkg::OP_START: begin
              st_d = eer_pkg::C_START;
              sda_low_d = 1'b0;
            end
            eer_pkg::OP_STOP: begin
              st_d = eer_pkg::C_STOP;
              sda_low_d = 1'b1;
            end
            eer_pkg::OP_WRITE: begin
              st_d = eer_pkg::C_BIT;
              sh_d = {pwdata[15:8], 1'b1};   // ninth bit released
              sda_low_d = !pwdata[15];
            end
            eer_pkg::OP_READ: begin
              st_d = eer_pkg::C_BIT;
              sh_d = {8'hff, !pwdata[eer_pkg::CMD_ACK_BIT]};
              sda_low_d = 1'b0;
            end
          endcase
        end
      end
      // start: scl low, release, sda falls while scl high, scl low
      eer_pkg::C_START: if (tick) begin
        ph_d = ph_q + 2'h1;
        unique case (ph_q)
          2'h0: scl_low_d = 1'b0;
          2'h1: sda_low_d = 1'b1;
          2'h2: scl_low_d = 1'b1;
          2'h3: st_d = eer_pkg::C_IDLE;
        endcase
      end
      // stop: sda rises while scl high
      eer_pkg::C_STOP: if (tick) begin
        ph_d = ph_q + 2'h1;
        unique case (ph_q)
          2'h0: scl_low_d = 1'b0;
          2'h1: sda_low_d = 1'b0;
          2'h2: ;
          2'h3: st_d = eer_pkg::C_IDLE;
        endcase
      end
      // one bit per four quarters; sda moves only while scl is low
      eer_pkg::C_BIT: if (tick) begin
        ph_d = ph_q + 2'h1;
        unique case (ph_q)
          2'h0: scl_low_d = 1'b0;
          2'h1: rx_d = {rx_q[7:0], sda_s_q};
          2'h2: scl_low_d = 1'b1;
          2'h3: begin
            if (bitn_q == 4'h8) begin
              st_d = eer_pkg::C_IDLE;
              ack_d = !rx_q[0];
              sda_low_d = 1'b0;
            end else begin
              sh_d = {sh_q[7:0], 1'b1};
              sda_low_d = !sh_q[7];
              bitn_d = bitn_q + 4'h1;
            end
          end
        endcase
      end
      default: st_d = eer_pkg::C_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= eer_pkg::C_IDLE;
      tick_q <= 8'h0; ph_q <= 2'h0; bitn_q <= 4'h0;
      sh_q <= 9'h1ff; rx_q <= 9'h0; ack_q <= 1'b0;
      scl_low_q <= 1'b0; sda_low_q <= 1'b0;
      sda_m_q <= 1'b1; sda_s_q <= 1'b1;
      prdata_q_w <= 32'h0; pready_q_w <= 1'b0;
    end else begin
      st_q <= st_d;
      tick_q <= tick_d; ph_q <= ph_d; bitn_q <= bitn_d;
      sh_q <= sh_d; rx_q <= rx_d; ack_q <= ack_d;
      scl_low_q <= scl_low_d; sda_low_q <= sda_low_d;
      sda_m_q <= bus.sda;          // synchroniser
      sda_s_q <= sda_m_q;
      prdata_q_w <= prdata_d; pready_q_w <= pready_d;
    end
  end

endmodule

// ---- verif/eer_link_chk.sv ----
// link checker watching the two-wire lines between target and controller
`timescale 1ns/1ps
module eer_link_chk #(
  parameter logic [2:0] SEL = 3'b000
) (
  // clock and reset
  input logic pclk,
  input logic presetn,
  // resolved lines and drive enables
  input logic scl,
  input logic sda,
  input logic ctl_scl_oe,
  input logic ctl_sda_oe,
  input logic dev_sda_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // --------------------------------------------------------------------
  // framing tracker
  // --------------------------------------------------------------------
  logic       scl_q, sda_q, first_q, first_d, tx_q, tx_d, nak_q, nak_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic       rise, ninth, start, stop, hdr_ok;
  assign rise   = scl && !scl_q;
  assign ninth  = rise && (cnt_q == 4'h8);
  assign start  = scl && scl_q && sda_q && !sda;
  assign stop   = scl && scl_q && !sda_q && sda;
  assign hdr_ok = (sh_q[7:4] == eer_pkg::HDR_ARRAY ||
                   sh_q[7:4] == eer_pkg::HDR_SPECIAL) && sh_q[3:1] == SEL;

  // start or stop restarts framing; read mode only after an acked header
  always_comb begin
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    first_d = first_q;
    tx_d    = tx_q;
    nak_d   = nak_q;
    if (start || stop) begin
      cnt_d   = 4'h0;
      first_d = start;
      tx_d    = 1'b0;
      nak_d   = 1'b0;
    end else if (rise) begin
      cnt_d = ninth ? 4'h0 : cnt_q + 4'h1;
      if (!ninth) begin
        sh_d = {sh_q[6:0], sda};
      end
      if (ninth) begin
        first_d = 1'b0;
        tx_d    = first_q ? (sh_q[0] && !sda) : tx_q;
        nak_d   = nak_q || (tx_q && sda);
      end
    end
  end

  // registers; idle lines are high so reset them high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_q, sda_q, first_q, tx_q, nak_q} <= 5'h18;
      cnt_q <= 4'h0;
      sh_q  <= 8'h00;
    end else begin
      {scl_q, sda_q, first_q, tx_q, nak_q} <= {scl, sda, first_d, tx_d, nak_d};
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  a_reset_quiet: assert property (disable iff (1'b0)
    !presetn |-> !dev_sda_oe && !ctl_sda_oe && !ctl_scl_oe)
    else $error("line driven during reset");
  a_addr_ack_good: assert property (
    first_q && ninth && hdr_ok |-> dev_sda_oe && !sda)
    else $error("matching address not acknowledged");
  a_addr_nack_bad: assert property (
    first_q && ninth && !hdr_ok |-> !dev_sda_oe)
    else $error("foreign address acknowledged");
  a_ack_release: assert property (
    tx_q && ninth |-> !dev_sda_oe)
    else $error("target holds data in ack slot");
  a_nack_silent: assert property (
    nak_q |-> !dev_sda_oe)
    else $error("target drives after nack");
  a_data_steady: assert property (
    scl && scl_q |-> $stable(dev_sda_oe))
    else $error("target data moved while clock high");
  a_no_dev_cond: assert property (
    scl && scl_q && (sda != sda_q) |-> !dev_sda_oe && !$past(dev_sda_oe))
    else $error("target made a start or stop");
  a_stop_idle: assert property (
    stop |=> !dev_sda_oe [*8])
    else $error("target active after stop");

  // main scenarios reached
  cover property (first_q && ninth && !sda);
  cover property (first_q && ninth && sda);
  cover property (tx_q && ninth && sda);
endmodule

// ---- verif/testbench.sv ----
// self-checking bench: apb-driven controller reading the eeprom target
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
    end \
  end

module testbench;
  // id value is arbitrary; uneven bytes expose ordering slips
  localparam logic [127:0] UIDV = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  localparam logic [2:0]   SEL  = 3'b000;
  localparam logic [7:0]   SW   = {eer_pkg::HDR_SPECIAL, SEL, 1'b0};
  localparam logic [7:0]   ARW  = {eer_pkg::HDR_ARRAY, SEL, 1'b0};
  localparam logic [7:0]   BAD [3] = '{8'hb3, 8'h91, 8'ha9};

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  cfg_byte;
  logic        page_locked, in_session;
  logic [12:0] addr_count;
  int          err_total, checks_done;

  // --------------------------------------------------------------------
  // the two ends joined by the link
  // --------------------------------------------------------------------
  eer_if link ();
  eer_ctl u_eer_ctl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
                     .pwdata, .prdata, .pready, .pslverr, .bus(link));
  eer_dev #(.UID_VAL(UIDV)) u_eer_dev (.pclk, .presetn, .cfg_byte,
    .page_locked, .addr_count, .in_session, .bus(link));
  eer_link_chk #(.SEL(SEL)) u_chk (.pclk, .presetn, .scl(link.scl),
    .sda(link.sda), .ctl_scl_oe(link.ctl_scl_oe),
    .ctl_sda_oe(link.ctl_sda_oe), .dev_sda_oe(link.dev_sda_oe));

  // clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // one apb transfer; an idle cycle follows so psel never toggles twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // one link command, then poll until the controller is idle again
  task automatic op(input logic [1:0] c, input logic k, input logic [7:0] b);
    apb(1'b1, eer_pkg::OFS_CMD, {16'h0000, b, 5'h00, k, c});
    do apb(1'b0, eer_pkg::OFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task automatic sta();
    op(eer_pkg::OP_START, 1'b0, 8'h00);
  endtask
  task automatic sto();
    op(eer_pkg::OP_STOP, 1'b0, 8'h00);
  endtask
  task automatic wb(input logic [7:0] b, input logic ak);
    op(eer_pkg::OP_WRITE, 1'b0, b);
    `CHK("ack", ak, rd[1])
  endtask
  task automatic rb(input logic k, input logic [7:0] e);
    op(eer_pkg::OP_READ, k, 8'h00);
    `CHK("rx byte", e, rd[15:8])
  endtask

  // dummy write of a special address, then a special read header
  task automatic dw(input logic [7:0] hi, input logic [7:0] lo);
    sta();
    wb(SW, 1'b1);
    wb(hi, 1'b1);
    wb(lo, 1'b1);
    sta();
    wb(SW | 8'h01, 1'b1);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog: the tests need roughly a seventh of this span
  initial begin
    #4_000_000;
    err_total++;
    tally_and_finish();
  end

  // --------------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------------
  initial begin
    presetn     <= 1'b0;  // nba: async resets see the edge at time zero
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    cfg_byte    = eer_pkg::CFG_RESET;
    page_locked = 1'b0;
    err_total   = 0;
    checks_done = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // array stream across the top of memory
    sta();
    wb(ARW, 1'b1);
    wb(8'h1f, 1'b1);
    wb(8'hfe, 1'b1);
    sta();
    wb(ARW | 8'h01, 1'b1);
    rb(1'b1, eer_pkg::ARRAY_FILL);
    `CHK("counter", 13'h1fff, addr_count)
    rb(1'b1, eer_pkg::ARRAY_FILL);
    `CHK("counter", 13'h0000, addr_count)
    rb(1'b0, eer_pkg::ARRAY_FILL);
    `CHK("counter", 13'h0000, addr_count)
    sto();
    `CHK("session", 1'b0, in_session)
    // config byte as delivered and with the protect flag set
    for (int i = 0; i < 2; i++) begin
      cfg_byte <= i ? 8'h02 : eer_pkg::CFG_RESET;
      dw(8'h06, 8'h00);
      rb(1'b1, i ? 8'h1f : 8'h1d);
      rb(1'b1, i ? 8'h1f : 8'h1d);
      rb(1'b0, i ? 8'h1f : 8'h1d);
      sto();
    end
    cfg_byte <= eer_pkg::CFG_RESET;
    // secure page from its last byte: counter must fold to offset zero
    dw(8'h00, 8'h3f);
    rb(1'b1, eer_pkg::ARRAY_FILL);
    `CHK("counter", 13'h0000, addr_count)
    rb(1'b0, eer_pkg::ARRAY_FILL);
    sto();
    // id: sixteen bytes, then the first again
    dw(8'h02, 8'h00);
    for (int i = 0; i < 17; i++) begin
      rb(i < 16, UIDV[127 - 8 * (i % 16) -: 8]);
    end
    sto();
    // lock status both ways
    for (int k = 0; k < 2; k++) begin
      page_locked <= k[0];
      dw(8'h04, 8'h00);
      rb(1'b0, {6'h00, k[0], 1'b0});
      sto();
    end
    // secure write probe: refused when locked, then start and stop
    for (int k = 1; k >= 0; k--) begin
      page_locked <= k[0];
      sta();
      wb(SW, 1'b1);
      wb(8'h00, 1'b1);
      wb(8'h00, 1'b1);
      wb(8'h5a, !k[0]);
      sta();
      sto();
    end
    // foreign headers and select bits, then a good read recovers
    foreach (BAD[i]) begin
      sta();
      wb(BAD[i], 1'b0);
      sto();
    end
    sta();
    wb(ARW | 8'h01, 1'b1);
    rb(1'b0, eer_pkg::ARRAY_FILL);
    sto();
    tally_and_finish();
  end
endmodule
